// File: rtl/pdc_pkg.sv
// constants shared by the peripheral controller dma control block
package pdc_pkg;

    // command codes on the microprocessor bus
    localparam logic [7:0]  CMD_CFG_WR     = 8'hF0;
    localparam logic [7:0]  CMD_CFG_RD     = 8'hF1;
    localparam logic [7:0]  CMD_CNT_WR     = 8'hF2;
    localparam logic [7:0]  CMD_CNT_RD     = 8'hF3;
    localparam logic [7:0]  CMD_SOFT_RST   = 8'hF6;

    // dma_setup_word field positions
    localparam int          CFG_CNT_EOT_BIT = 15;
    localparam int          CFG_SHORT_BIT   = 14;
    localparam int          CFG_EP_HI       = 7;
    localparam int          CFG_EP_LO       = 4;
    localparam int          CFG_RUN_BIT     = 3;
    localparam int          CFG_BURST_HI    = 1;
    localparam int          CFG_BURST_LO    = 0;

    // reset values
    localparam logic [15:0] CFG_RST_VAL    = 16'h0000;
    localparam logic [15:0] CNT_RST_VAL    = 16'h0000;

    // endpoint buffer: packet length header skipped by dma
    localparam int          BUF_PTR_W      = 11;
    localparam logic [10:0] HDR_SKIP_BYTES = 11'h002;

    // burst length codes and sizes in bytes
    localparam logic [1:0]  BURST_SEL_1    = 2'h0;
    localparam logic [1:0]  BURST_SEL_4    = 2'h1;
    localparam logic [1:0]  BURST_SEL_8    = 2'h2;
    localparam logic [4:0]  BURST_BYTES_1  = 5'h01;
    localparam logic [4:0]  BURST_BYTES_4  = 5'h04;
    localparam logic [4:0]  BURST_BYTES_8  = 5'h08;
    localparam logic [4:0]  BURST_BYTES_16 = 5'h10;

    // positions in the synchronised pin vector
    localparam int          PIN_W          = 22;
    localparam int          PIN_CS_N       = 21;
    localparam int          PIN_WR_N       = 20;
    localparam int          PIN_RD_N       = 19;
    localparam int          PIN_A0         = 18;
    localparam int          PIN_DACK_N     = 17;
    localparam int          PIN_EOT_N      = 16;
    localparam logic [21:0] PIN_RST_VAL    = 22'h3F0000;

    // command bus phase
    typedef enum logic [1:0]
    {
        BUS_IDLE = 2'b00,
        BUS_DATA = 2'b01,
        BUS_DONE = 2'b10
    } pdc_bus_t;

endpackage

// File: rtl/pdc_pin_sync.sv
// three-flop pin synchroniser, a change counts once stages two and three agree
`timescale 1ns/1ps
module pdc_pin_sync
#(
    parameter int          W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
)
(
    input  wire logic         clk_sys,
    input  wire logic         rst,
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] pin_stable
);
    typedef struct packed
    {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] st;
    } pdc_sync_t;

    pdc_sync_t sy_r;
    pdc_sync_t sy_nxt;

    initial
    begin
        if (W < 1)
            $error("pdc_pin_sync: width must be at least one");
    end

    // shift chain; stable value follows only where stages agree
    always_comb
    begin
        sy_nxt    = sy_r;
        sy_nxt.s1 = pin_in;
        sy_nxt.s2 = sy_r.s1;
        sy_nxt.s3 = sy_r.s2;
        for (int i = 0; i < W; i++)
        begin
            if (sy_r.s2[i] == sy_r.s3[i])
                sy_nxt.st[i] = sy_r.s3[i];
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            sy_r <= '{s1: RST_VAL, s2: RST_VAL, s3: RST_VAL, st: RST_VAL};
        else
            sy_r <= sy_nxt;
    end

    assign pin_stable = sy_r.st;
endmodule

// File: rtl/pdc_byte_cnt.sv
// working byte counter: reload, decrement per byte, zero-reach pulse
`timescale 1ns/1ps
module pdc_byte_cnt
#(
    parameter int W = 16
)
(
    input  wire logic         clk_sys,
    input  wire logic         rst,
    input  wire logic         load,
    input  wire logic [W-1:0] load_val,
    input  wire logic         dec,
    output logic      [W-1:0] count,
    output logic              hit_zero
);
    typedef struct packed
    {
        logic [W-1:0] cnt;
        logic         zero;
    } pdc_cnt_t;

    pdc_cnt_t c_r;
    pdc_cnt_t c_nxt;

    initial
    begin
        if (W < 2)
            $error("pdc_byte_cnt: width must be at least two");
    end

    // load wins over decrement; never wraps below zero
    always_comb
    begin
        c_nxt      = c_r;
        c_nxt.zero = 1'b0;
        if (load)
            c_nxt.cnt = load_val;
        else if (dec && (c_r.cnt != '0))
        begin
            c_nxt.cnt  = c_r.cnt - W'(1);
            c_nxt.zero = (c_r.cnt == W'(1));
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            c_r <= '0;
        else
            c_r <= c_nxt;
    end

    assign count    = c_r.cnt;
    assign hit_zero = c_r.zero;
endmodule

// File: rtl/pdc_dma_ctrl.sv
// dma configuration, byte counter and soft reset of the peripheral controller
//
// Notes on behaviour
// - usb bus reset clears dma_run_bit only; other setup fields and count stay
// - setup word written by command F0, read by F1, one 16-bit data word
// - count_zero_eot_enable set: end-of-transfer when working counter reaches zero
// - short_packet_eot_mode set: short or empty OUT packet raises end-of-transfer
// - bits 7 to 4 select the endpoint that dma serves
// - writing run 1 starts dma, writing 0 stops any transfer at once
// - reading the run bit shows the live dma state
// - burst field 00/01/10/11 gives 1/4/8/16 bytes per burst
// - writing the count register sets the transfer byte total
// - reading the count register returns remaining bytes of current transfer
// - each re-enable reloads the working counter from the programmed count
// - count register survives usb bus reset, hardware reset gives zero
// - count register written by command F2, read by F3, one 16-bit word
// - command F6 without data resets setup, count and bus state like the hardware reset, strobe edge history and pin sync excepted
// - IN buffer holds data for the host, OUT buffer data from it
// - dma skips the two-byte length header, starting at byte two
// - external end-of-transfer on IN endpoint flushes the buffer to the host
`timescale 1ns/1ps
module pdc_dma_ctrl
    import pdc_pkg::*;
#(
    parameter int CNT_W = 16
)
(
    input  wire logic                 clk_sys,
    input  wire logic                 rst,
    input  wire logic                 cs_n,
    input  wire logic                 wr_n,
    input  wire logic                 rd_n,
    input  wire logic                 a0,
    input  wire logic [15:0]          data_in,
    output logic      [15:0]          data_out,
    output logic                      data_oe,
    input  wire logic                 dack_n,
    input  wire logic                 eot_n,
    output logic                      dreq,
    input  wire logic                 usb_bus_reset,
    input  wire logic                 ep_is_in,
    input  wire logic                 short_pkt_rx,
    input  wire logic                 buf_ready,
    output logic                      byte_strobe,
    output logic      [BUF_PTR_W-1:0] buf_ptr,
    output logic      [3:0]           dma_endpoint_select,
    output logic                      dma_run,
    output logic                      eot_event,
    output logic                      flush_in_buf
);
    typedef struct packed
    {
        pdc_bus_t             bus;
        logic [7:0]           cmd;
        logic                 wr_prev;
        logic                 rd_prev;
        logic                 dack_prev;
        logic                 eot_prev;
        logic                 wr_cs;
        logic                 wr_a0;
        logic [15:0]          wr_data;
        logic [15:0]          dout;
        logic                 oe;
        logic                 count_zero_eot_enable;
        logic                 short_packet_eot_mode;
        logic [3:0]           ep_sel;
        logic                 dma_run_bit;
        logic [1:0]           burst_size_select;
        logic [15:0]          transfer_byte_count;
        logic [4:0]           burst_cnt;
        logic [BUF_PTR_W-1:0] ptr;
        logic                 dreq;
        logic                 strobe;
        logic                 eot;
        logic                 flush;
    } pdc_state_t;

    localparam pdc_state_t ST_RST = '{
        bus:                   BUS_IDLE,
        wr_prev:               1'b0, // strobes idle inactive, no false edge
        rd_prev:               1'b0,
        dack_prev:             1'b0,
        eot_prev:              1'b0,
        count_zero_eot_enable: CFG_RST_VAL[CFG_CNT_EOT_BIT],
        short_packet_eot_mode: CFG_RST_VAL[CFG_SHORT_BIT],
        ep_sel:                CFG_RST_VAL[CFG_EP_HI:CFG_EP_LO],
        dma_run_bit:           CFG_RST_VAL[CFG_RUN_BIT],
        burst_size_select:     CFG_RST_VAL[CFG_BURST_HI:CFG_BURST_LO],
        transfer_byte_count:   CNT_RST_VAL,
        default:               '0
    };

    pdc_state_t           s_r;
    pdc_state_t           s_nxt;
    logic [PIN_W-1:0]     pins_st;
    logic [CNT_W-1:0]     work_cnt;
    logic                 work_zero;
    logic                 cnt_load;
    logic [CNT_W-1:0]     cnt_load_val;
    logic                 cnt_dec;

    initial
    begin
        if (CNT_W != 16)
            $error("pdc_dma_ctrl: counter width must be 16");
    end

    // bytes per burst for a burst select code
    function automatic logic [4:0] burst_bytes(input logic [1:0] sel);
        logic [4:0] n;
        n = BURST_BYTES_16;
        if (sel == BURST_SEL_1)
            n = BURST_BYTES_1;
        else if (sel == BURST_SEL_4)
            n = BURST_BYTES_4;
        else if (sel == BURST_SEL_8)
            n = BURST_BYTES_8;
        return n;
    endfunction

    // all bus and dma pins cross into clk_sys here
    pdc_pin_sync
    #(
        .W       (PIN_W),
        .RST_VAL (PIN_RST_VAL)
    )
    u_sync
    (
        .clk_sys    (clk_sys),
        .rst        (rst),
        .pin_in     ({cs_n, wr_n, rd_n, a0, dack_n, eot_n, data_in}),
        .pin_stable (pins_st)
    );

    // working counter behind the readable count register
    pdc_byte_cnt
    #(
        .W (CNT_W)
    )
    u_cnt
    (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .load     (cnt_load),
        .load_val (cnt_load_val),
        .dec      (cnt_dec),
        .count    (work_cnt),
        .hit_zero (work_zero)
    );

    // next state: command bus, setup fields, dma engine
    always_comb
    begin
        logic       cs_st;
        logic       wr_st;
        logic       rd_st;
        logic       a0_st;
        logic       dack_st;
        logic       eot_st;
        logic       wr_rise;
        logic       rd_fall;
        logic       rd_rise;
        logic       byte_moved;
        logic       soft_rst;
        logic       start;
        logic       stop;
        logic       burst_end;
        cs_st      = ~pins_st[PIN_CS_N];
        wr_st      = ~pins_st[PIN_WR_N];
        rd_st      = ~pins_st[PIN_RD_N];
        a0_st      = pins_st[PIN_A0];
        dack_st    = ~pins_st[PIN_DACK_N];
        eot_st     = ~pins_st[PIN_EOT_N];
        wr_rise    = s_r.wr_prev && !wr_st;
        rd_fall    = !s_r.rd_prev && rd_st;
        rd_rise    = s_r.rd_prev && !rd_st;
        byte_moved = !s_r.dack_prev && dack_st && s_r.dma_run_bit;
        s_nxt      = s_r;
        soft_rst   = 1'b0;
        start      = 1'b0;
        stop       = 1'b0;
        burst_end  = 1'b0;
        cnt_load     = 1'b0;
        cnt_load_val = work_cnt;
        cnt_dec      = 1'b0;

        // edge detect on the agreed pin levels
        s_nxt.wr_prev   = wr_st;
        s_nxt.rd_prev   = rd_st;
        s_nxt.dack_prev = dack_st;
        s_nxt.eot_prev  = eot_st;
        s_nxt.strobe = 1'b0;
        s_nxt.eot    = 1'b0;
        s_nxt.flush  = 1'b0;

        // capture select, phase and data while the write strobe is low
        if (wr_st)
        begin
            s_nxt.wr_cs   = cs_st;
            s_nxt.wr_a0   = a0_st;
            s_nxt.wr_data = pins_st[15:0];
        end

        // write strobe end: command phase or data phase
        if (wr_rise && s_r.wr_cs)
        begin
            if (s_r.wr_a0)
            begin
                s_nxt.cmd = s_r.wr_data[7:0];
                s_nxt.bus = BUS_DATA;
                if (s_r.wr_data[7:0] == CMD_SOFT_RST)
                    soft_rst = 1'b1;
            end
            else if (s_r.bus == BUS_DATA)
            begin
                s_nxt.bus = BUS_DONE;
                if (s_r.cmd == CMD_CFG_WR)
                begin
                    s_nxt.count_zero_eot_enable = s_r.wr_data[CFG_CNT_EOT_BIT];
                    s_nxt.short_packet_eot_mode = s_r.wr_data[CFG_SHORT_BIT];
                    s_nxt.ep_sel = s_r.wr_data[CFG_EP_HI:CFG_EP_LO];
                    s_nxt.burst_size_select = s_r.wr_data[CFG_BURST_HI:CFG_BURST_LO];
                    if (s_r.wr_data[CFG_RUN_BIT])
                        start = !s_r.dma_run_bit;
                    else
                        stop = 1'b1;
                end
                else if (s_r.cmd == CMD_CNT_WR)
                begin
                    s_nxt.transfer_byte_count = s_r.wr_data;
                    if (!s_r.dma_run_bit)
                    begin
                        cnt_load     = 1'b1;
                        cnt_load_val = s_r.wr_data;
                    end
                end
            end
        end

        // read strobe start: drive the selected word
        if (rd_fall && cs_st && !a0_st && (s_r.bus == BUS_DATA))
        begin
            s_nxt.oe = 1'b1;
            if (s_r.cmd == CMD_CFG_RD)
                s_nxt.dout = {s_r.count_zero_eot_enable, s_r.short_packet_eot_mode, 6'h00,
                              s_r.ep_sel, s_r.dma_run_bit, 1'b0, s_r.burst_size_select};
            else if (s_r.cmd == CMD_CNT_RD)
                s_nxt.dout = work_cnt;
            else
                s_nxt.dout = 16'h0000;
        end

        // read strobe end releases the data lines
        if (rd_rise && s_r.oe)
        begin
            s_nxt.oe  = 1'b0;
            s_nxt.bus = BUS_DONE;
        end

        // byte transfer bookkeeping
        if (byte_moved)
        begin
            s_nxt.strobe = 1'b1;
            s_nxt.ptr    = s_r.ptr + BUF_PTR_W'(1);
            cnt_dec      = 1'b1;
            if (s_r.burst_cnt == burst_bytes(s_r.burst_size_select) - 5'h01)
            begin
                s_nxt.burst_cnt = 5'h00;
                burst_end       = 1'b1;
            end
            else
                s_nxt.burst_cnt = s_r.burst_cnt + 5'h01;
        end

        // end-of-transfer sources while running
        if (s_r.dma_run_bit)
        begin
            if (work_zero && s_r.count_zero_eot_enable)
            begin
                stop      = 1'b1;
                s_nxt.eot = 1'b1;
            end
            if (short_pkt_rx && s_r.short_packet_eot_mode && !ep_is_in)
            begin
                stop      = 1'b1;
                s_nxt.eot = 1'b1;
            end
            if (!s_r.eot_prev && eot_st)
            begin
                stop        = 1'b1;
                s_nxt.eot   = 1'b1;
                s_nxt.flush = ep_is_in;
            end
        end

        // bus reset stops dma, setup fields and count are left alone
        if (usb_bus_reset)
            stop = 1'b1;

        // start reloads the counter and skips the length header
        if (start)
        begin
            s_nxt.dma_run_bit = 1'b1;
            s_nxt.burst_cnt   = 5'h00;
            s_nxt.ptr         = HDR_SKIP_BYTES;
            cnt_load          = 1'b1;
            cnt_load_val      = s_r.transfer_byte_count;
        end
        if (stop)
        begin
            s_nxt.dma_run_bit = 1'b0;
            s_nxt.burst_cnt   = 5'h00;
        end

        // request while running, buffer ready, not in a byte-moved or burst-end cycle and, with count_zero_eot_enable set, bytes remain
        s_nxt.dreq = s_nxt.dma_run_bit && buf_ready && !burst_end && !byte_moved
                     && !(s_nxt.count_zero_eot_enable && (work_cnt == 16'h0000) && !start);

        // soft reset returns every register except wr_prev, rd_prev and the pin sync stages to its reset value
        if (soft_rst)
        begin
            s_nxt         = ST_RST;
            s_nxt.wr_prev = wr_st;
            s_nxt.rd_prev = rd_st;
            cnt_load      = 1'b1;
            cnt_load_val  = CNT_RST_VAL;
        end
    end

    // single state register
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            s_r <= ST_RST;
        else
            s_r <= s_nxt;
    end

    // outputs straight from the state register
    assign data_out            = s_r.dout;
    assign data_oe             = s_r.oe;
    assign dreq                = s_r.dreq;
    assign byte_strobe         = s_r.strobe;
    assign buf_ptr             = s_r.ptr;
    assign dma_endpoint_select = s_r.ep_sel;
    assign dma_run             = s_r.dma_run_bit;
    assign eot_event           = s_r.eot;
    assign flush_in_buf        = s_r.flush;
endmodule

// File: tb/pdc_dma_ctrl_properties.sv
// port assertions for the dma control block
`timescale 1ns/1ps
module pdc_dma_ctrl_properties
    import pdc_pkg::*;
(
    input wire logic                 clk_sys,
    input wire logic                 rst,
    input wire logic                 cs_n,
    input wire logic                 rd_n,
    input wire logic                 a0,
    input wire logic                 data_oe,
    input wire logic                 usb_bus_reset,
    input wire logic                 ep_is_in,
    input wire logic                 byte_strobe,
    input wire logic [BUF_PTR_W-1:0] buf_ptr,
    input wire logic                 dreq,
    input wire logic                 dma_run,
    input wire logic                 eot_event,
    input wire logic                 flush_in_buf
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    // a byte moved, and the start of a transfer
    sequence s_byte;
        byte_strobe;
    endsequence
    sequence s_start;
        $rose(dma_run);
    endsequence

    property p_ptr_step;
        s_byte |-> buf_ptr == $past(buf_ptr) + 11'h001;
    endproperty
    property p_ptr_start;
        s_start |-> buf_ptr == HDR_SKIP_BYTES;
    endproperty
    property p_byte_live;
        s_byte |-> $past(dma_run) && !dreq;
    endproperty
    property p_dreq_run;
        dreq |-> dma_run;
    endproperty
    property p_eot_stop;
        eot_event |-> !dma_run && !dreq ##1 !eot_event;
    endproperty
    property p_bus_rst;
        usb_bus_reset |=> !dma_run;
    endproperty
    property p_flush;
        flush_in_buf |-> $past(ep_is_in) && $past(dma_run) && !dma_run;
    endproperty
    property p_oe;
        $rose(data_oe) |-> !rd_n && !cs_n && !a0;
    endproperty

    a_ptr_step: assert property (p_ptr_step) else $error("buf_ptr did not step by one");
    a_ptr_start: assert property (p_ptr_start) else $error("buf_ptr not past header");
    a_byte_live: assert property (p_byte_live) else $error("byte moved while stopped");
    a_dreq_run: assert property (p_dreq_run) else $error("dreq while stopped");
    a_eot_stop: assert property (p_eot_stop) else $error("eot did not stop dma");
    a_bus_rst: assert property (p_bus_rst) else $error("bus reset kept dma running");
    a_flush: assert property (p_flush) else $error("flush without in endpoint stop");
    a_oe: assert property (p_oe) else $error("data driven without read");
endmodule

bind pdc_dma_ctrl pdc_dma_ctrl_properties i_props
(
    .clk_sys(clk_sys), .rst(rst), .cs_n(cs_n), .rd_n(rd_n), .a0(a0), .data_oe(data_oe),
    .usb_bus_reset(usb_bus_reset), .ep_is_in(ep_is_in), .byte_strobe(byte_strobe),
    .buf_ptr(buf_ptr), .dreq(dreq), .dma_run(dma_run), .eot_event(eot_event),
    .flush_in_buf(flush_in_buf)
);

// File: tb/pdc_dma_partner.sv
// external dma controller: one dack pulse per byte while dreq is up
`timescale 1ns/1ps
module pdc_dma_partner
(
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        dreq,
    input  wire logic        go,
    input  wire logic        slow,
    output logic             dack_n,
    output logic      [15:0] bytes_seen
);
    logic [4:0] hold_r;

    // each dack level held seven clocks, slow mode idles longer
    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            dack_n <= 1'b1;
            hold_r <= 5'h00;
            bytes_seen <= 16'h0000;
        end
        else if (hold_r != 5'h00)
            hold_r <= hold_r - 5'h01;
        else if (!dack_n)
        begin
            dack_n <= 1'b1;
            hold_r <= slow ? 5'h14 : 5'h06;
        end
        else if (dreq && go)
        begin
            dack_n <= 1'b0;
            hold_r <= 5'h06;
            bytes_seen <= bytes_seen + 16'h0001;
        end
    end
endmodule

// File: tb/test_usb_device_dma_control.sv
// self-checking bench for the dma control block
`timescale 1ns/1ps
module test_usb_device_dma_control
    import pdc_pkg::*;
;
    logic        clk_sys, rst, cs_n, wr_n, rd_n, a0, dack_n, eot_n, usb_bus_reset;
    logic        ep_is_in, short_pkt_rx, buf_ready, go, slow, data_oe, dreq;
    logic        byte_strobe, dma_run, eot_event, flush_in_buf;
    logic [15:0] data_in, data_out, bytes_seen, b0;
    logic [10:0] buf_ptr;
    logic [3:0]  ep_sel;
    int          failures = 0, samples_checked = 0, eot_cnt = 0, flush_cnt = 0, e0, k;

    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    pdc_dma_ctrl #(.CNT_W(16)) i_dut
    (
        .clk_sys(clk_sys), .rst(rst), .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n), .a0(a0),
        .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .dack_n(dack_n),
        .eot_n(eot_n), .dreq(dreq), .usb_bus_reset(usb_bus_reset), .ep_is_in(ep_is_in),
        .short_pkt_rx(short_pkt_rx), .buf_ready(buf_ready), .byte_strobe(byte_strobe),
        .buf_ptr(buf_ptr), .dma_endpoint_select(ep_sel), .dma_run(dma_run),
        .eot_event(eot_event), .flush_in_buf(flush_in_buf)
    );

    pdc_dma_partner i_partner
    (
        .clk_sys(clk_sys), .rst(rst), .dreq(dreq), .go(go), .slow(slow),
        .dack_n(dack_n), .bytes_seen(bytes_seen)
    );

    // pulse counters for end-of-transfer and flush
    always @(posedge clk_sys)
    begin
        if (eot_event === 1'b1)
            eot_cnt <= eot_cnt + 1;
        if (flush_in_buf === 1'b1)
            flush_cnt <= flush_cnt + 1;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
            failures++;
        end
    endtask

    // command phase, each strobe level six clocks for the pin sync
    task automatic bus_cmd(input logic [7:0] code);
        @(posedge clk_sys);
        cs_n <= 1'b0;
        a0 <= 1'b1;
        data_in <= {8'h00, code};
        wr_n <= 1'b0;
        tick(6);
        wr_n <= 1'b1;
        tick(6);
        a0 <= 1'b0;
    endtask

    task automatic bus_wr(input logic [7:0] code, input logic [15:0] word);
        bus_cmd(code);
        data_in <= word;
        wr_n <= 1'b0;
        tick(6);
        wr_n <= 1'b1;
        tick(6);
        cs_n <= 1'b1;
        data_in <= ~word;
        tick(2);
    endtask

    task automatic rd_chk(input logic [7:0] code, input logic [15:0] exp, input string what);
        bus_cmd(code);
        rd_n <= 1'b0;
        tick(8);
        #1;
        check("read enable", 16'h0001, {15'h0000, data_oe});
        check(what, exp, data_out);
        @(posedge clk_sys);
        rd_n <= 1'b1;
        tick(6);
        #1;
        check("read release", 16'h0000, {15'h0000, data_oe});
        @(posedge clk_sys);
        cs_n <= 1'b1;
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // watchdog over the whole sequence
    initial
    begin
        tick(30000);
        failures++;
        print_verdict();
    end

    initial
    begin
        {cs_n, wr_n, rd_n, a0, eot_n, buf_ready} = 6'h3F;
        {usb_bus_reset, ep_is_in, short_pkt_rx, go, slow} = 5'h00;
        data_in = 16'h0000;
        rst = 1'b1;
        tick(5);
        rst <= 1'b0;
        tick(3);
        rd_chk(CMD_CFG_RD, CFG_RST_VAL, "setup reset");
        rd_chk(CMD_CNT_RD, CNT_RST_VAL, "count reset");
        // reserved bits read back zero
        bus_wr(CMD_CFG_WR, 16'hFF57);
        rd_chk(CMD_CFG_RD, 16'hC053, "setup fields");
        check("endpoint", 16'h0005, {12'h000, ep_sel});
        for (int b = 0; b < 4; b++)
        begin
            bus_wr(CMD_CFG_WR, {14'h0028, b[1:0]});
            rd_chk(CMD_CFG_RD, {14'h0028, b[1:0]}, "burst code");
        end
        // counter-driven stop after six bytes
        bus_wr(CMD_CNT_WR, 16'h0006);
        rd_chk(CMD_CNT_RD, 16'h0006, "count write");
        b0 = bytes_seen;
        e0 = eot_cnt;
        go <= 1'b1;
        bus_wr(CMD_CFG_WR, 16'h8039);
        k = 0;
        while (dma_run !== 1'b0 && k < 600)
        begin
            tick(1);
            k++;
        end
        tick(10);
        #1;
        check("bytes moved", b0 + 16'h0006, bytes_seen);
        check("count eot", 16'h0001, 16'(eot_cnt - e0));
        check("buffer pointer", {5'h00, HDR_SKIP_BYTES} + 16'h0006, {5'h00, buf_ptr});
        rd_chk(CMD_CNT_RD, 16'h0000, "remaining");
        rd_chk(CMD_CFG_RD, 16'h8031, "run cleared");
        // re-enable reloads, slow partner stopped after two bytes
        go <= 1'b0;
        slow <= 1'b1;
        bus_wr(CMD_CFG_WR, 16'h0039);
        b0 = bytes_seen;
        go <= 1'b1;
        k = 0;
        while (bytes_seen !== b0 + 16'h0002 && k < 600)
        begin
            tick(1);
            k++;
        end
        go <= 1'b0;
        tick(30);
        rd_chk(CMD_CNT_RD, 16'h0004, "reloaded remaining");
        rd_chk(CMD_CFG_RD, 16'h0039, "run live");
        bus_wr(CMD_CFG_WR, 16'h0031);
        check("run off", 16'h0000, {15'h0000, dma_run});
        // external eot on an in endpoint, short mode kept clear
        ep_is_in <= 1'b1;
        e0 = flush_cnt;
        bus_wr(CMD_CFG_WR, 16'h0039);
        eot_n <= 1'b0;
        tick(6);
        eot_n <= 1'b1;
        tick(6);
        #1;
        check("flush", 16'h0001, 16'(flush_cnt - e0));
        check("eot pin stop", 16'h0000, {15'h0000, dma_run});
        // short packet on an out endpoint
        ep_is_in <= 1'b0;
        e0 = eot_cnt;
        bus_wr(CMD_CFG_WR, 16'h4039);
        short_pkt_rx <= 1'b1;
        @(posedge clk_sys);
        short_pkt_rx <= 1'b0;
        tick(3);
        #1;
        check("short eot", 16'h0001, 16'(eot_cnt - e0));
        check("short stop", 16'h0000, {15'h0000, dma_run});
        // usb bus reset clears run only
        bus_wr(CMD_CFG_WR, 16'h8039);
        usb_bus_reset <= 1'b1;
        @(posedge clk_sys);
        usb_bus_reset <= 1'b0;
        tick(3);
        rd_chk(CMD_CFG_RD, 16'h8031, "bus reset setup");
        rd_chk(CMD_CNT_RD, 16'h0006, "bus reset count");
        // soft reset command without data
        bus_cmd(CMD_SOFT_RST);
        cs_n <= 1'b1;
        tick(8);
        rd_chk(CMD_CFG_RD, CFG_RST_VAL, "soft reset setup");
        rd_chk(CMD_CNT_RD, CNT_RST_VAL, "soft reset count");
        print_verdict();
    end
endmodule
